// ===== hdl/transmit_line_output_port.sv
// module: transmit line output stage with analog, dual-rail and optical modes
//
// Behaviour
// - line side 1 and coding 1 selects dual-rail positive/negative rails
// - dual-rail, baud width 0: pulses last half the bit period
// - dual-rail, baud width 1: pulses last the whole bit period
// - dual-rail data launched on rising transmit clock edges
// - polarity bit inverts rails; rails are active low by default
// - digital outputs tristate until line side 1 and tristate bit 0
// - optical mode sends unipolar data at transmit clock rate on rising edges
// - optical NRZ holds each bit for the full bit period
// - optical CMI shifts on both clock edges per CMI coding
// - optical data active high by default; polarity bit inverts it
// - line side 1 and coding 0 selects single-rail optical mode
// - frame marker high during first bit of each frame, rising edge updated
// - frame marker only driven in optical single-rail mode
`timescale 1ns/1ps
module transmit_line_output_port
    import tx_line_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb register slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // symbol stream from the framer core
    input wire logic symValid,
    output logic symReady,
    input wire logic symFrameStart,
    input wire logic symPos,
    input wire logic symNeg,
    // transmit clock pin, asynchronous to mclk
    input wire logic transmit_clock,
    // analog line pins
    output logic tx_analog_line_a,
    output logic tx_analog_line_a_oe,
    output logic tx_analog_line_b,
    output logic tx_analog_line_b_oe,
    // digital line pins, shared between dual-rail and optical functions
    output logic tx_rail_positive,
    output logic tx_rail_positive_oe,
    output logic tx_rail_negative,
    output logic tx_rail_negative_oe
);

    typedef struct packed {
        // control register fields
        logic line_side_select;
        logic transmit_coding_select;
        logic transmit_tristate_ctl;
        logic baud_width_select;
        logic output_polarity_select;
        logic cmiSelect;
        // sticky status
        logic underrun;
        logic [FRAME_CNT_W-1:0] frameCount;
        // apb read data
        logic [31:0] prdata;
        // transmit clock synchroniser and edge history
        logic xclkMeta;
        logic xclkSync;
        logic xclkLast;
        // bit timing
        phase_t phase;
        logic cmiZero;
        logic cmiLevel;
        // unpolarised line levels
        logic pulsePos;
        logic pulseNeg;
        logic anaA;
        logic anaB;
        // pin levels and enables
        logic pinPos;
        logic pinNeg;
        logic pinA;
        logic pinB;
        logic digOe;
        logic anaOe;
    } port_t;

    port_t st_ff;
    port_t nxt_st;

    // buffer connection
    logic bufValid;
    logic bufReady;
    logic [SYM_W-1:0] bufData;
    logic [SYM_W-1:0] inSym;

    // decoded bus and timing events
    logic apbSetup;
    logic apbAccess;
    logic hitCtrl;
    logic hitStatus;
    logic xclkRise;
    logic xclkFall;
    line_mode_t mode;
    logic [SYM_W-1:0] sym;
    logic dataBit;
    logic opticalLevel;
    logic underrunEvt;
    logic underrunClr;
    logic [31:0] readWord;

    // frame start is packed with its own bit so both leave on one edge
    assign inSym = {symFrameStart, symPos, symNeg};

    tx_line_buffer u_buffer (
        .mclk(mclk),
        .rstn(rstn),
        .inValid(symValid),
        .inReady(symReady),
        .inData(inSym),
        .outValid(bufValid),
        .outReady(bufReady),
        .outData(bufData)
    );

    // one symbol is drained per transmit clock rising edge; the core stalls otherwise
    assign bufReady = xclkRise;

    // apb decode: zero wait states, unmapped addresses answer with pslverr
    assign apbSetup = psel & ~penable;
    assign apbAccess = psel & penable;
    assign hitCtrl = (paddr == ADDR_CTRL);
    assign hitStatus = (paddr == ADDR_STATUS);
    assign pready = 1'b1;
    assign pslverr = apbAccess & ~(hitCtrl | hitStatus);
    assign prdata = st_ff.prdata;

    // edges are taken from the second and third stages, never the first
    assign xclkRise = st_ff.xclkSync & ~st_ff.xclkLast;
    assign xclkFall = ~st_ff.xclkSync & st_ff.xclkLast;

    // line mode from the side and coding select bits
    always_comb begin
        if (!st_ff.line_side_select) begin
            mode = MODE_ANALOG;
        end else if (st_ff.transmit_coding_select) begin
            mode = MODE_DUAL;
        end else begin
            mode = MODE_OPTICAL;
        end
    end

    // an empty buffer at a bit boundary sends an idle symbol
    assign sym = bufValid ? bufData : '0;
    assign dataBit = sym[SYM_POS];
    assign underrunEvt = xclkRise & ~bufValid;
    assign underrunClr = apbAccess & pwrite & hitStatus & pstrb[0] & pwdata[ST_UNDERRUN];

    // optical level at a rising edge: nrz holds the bit, cmi ones alternate
    always_comb begin
        if (!st_ff.cmiSelect) begin
            opticalLevel = dataBit;
        end else if (dataBit) begin
            opticalLevel = ~st_ff.cmiLevel;
        end else begin
            opticalLevel = 1'b0;
        end
    end

    // read data mux; reserved bits read as zero
    always_comb begin
        readWord = 32'h0000_0000;
        if (hitCtrl) begin
            readWord[CTRL_LINE_SIDE] = st_ff.line_side_select;
            readWord[CTRL_CODING] = st_ff.transmit_coding_select;
            readWord[CTRL_TRISTATE] = st_ff.transmit_tristate_ctl;
            readWord[CTRL_BAUD] = st_ff.baud_width_select;
            readWord[CTRL_POLARITY] = st_ff.output_polarity_select;
            readWord[CTRL_CMI] = st_ff.cmiSelect;
        end else if (hitStatus) begin
            readWord[ST_UNDERRUN] = st_ff.underrun;
            readWord[ST_DIG_OE] = st_ff.digOe;
            readWord[ST_ANA_OE] = st_ff.anaOe;
            readWord[ST_MODE_HI:ST_MODE_LO] = mode;
            readWord[ST_BUF_VALID] = bufValid;
            readWord[ST_FRAME_HI:ST_FRAME_LO] = st_ff.frameCount;
        end
    end

    // next state of the whole port
    always_comb begin
        nxt_st = st_ff;

        // read data is captured in the setup cycle and stands through the access
        if (apbSetup) begin
            nxt_st.prdata = readWord;
        end

        // control register write takes effect at the access edge
        if (apbAccess && pwrite && hitCtrl && pstrb[0]) begin
            nxt_st.line_side_select = pwdata[CTRL_LINE_SIDE];
            nxt_st.transmit_coding_select = pwdata[CTRL_CODING];
            nxt_st.transmit_tristate_ctl = pwdata[CTRL_TRISTATE];
            nxt_st.baud_width_select = pwdata[CTRL_BAUD];
            nxt_st.output_polarity_select = pwdata[CTRL_POLARITY];
            nxt_st.cmiSelect = pwdata[CTRL_CMI];
        end

        // sticky underrun: a new event beats a clear in the same cycle
        nxt_st.underrun = (st_ff.underrun & ~underrunClr) | underrunEvt;

        // two-stage synchroniser plus edge history
        nxt_st.xclkMeta = transmit_clock;
        nxt_st.xclkSync = st_ff.xclkMeta;
        nxt_st.xclkLast = st_ff.xclkSync;

        // rising edge: start of a bit, every mode launches here
        if (xclkRise) begin
            nxt_st.phase = PH_FIRST;
            nxt_st.cmiZero = st_ff.cmiSelect & ~dataBit;
            if (st_ff.cmiSelect && dataBit) begin
                nxt_st.cmiLevel = ~st_ff.cmiLevel;
            end
            if (bufValid && sym[SYM_FRAME]) begin
                nxt_st.frameCount = st_ff.frameCount + 16'h0001;
            end
            case (mode)
                MODE_DUAL: begin
                    nxt_st.pulsePos = sym[SYM_POS];
                    nxt_st.pulseNeg = sym[SYM_NEG];
                    nxt_st.anaA = 1'b0;
                    nxt_st.anaB = 1'b0;
                end
                MODE_OPTICAL: begin
                    // data on the positive pin, marker on the negative pin
                    nxt_st.pulsePos = opticalLevel;
                    nxt_st.pulseNeg = sym[SYM_FRAME];
                    nxt_st.anaA = 1'b0;
                    nxt_st.anaB = 1'b0;
                end
                MODE_ANALOG: begin
                    // analog pulse pair drives the transformer halves
                    nxt_st.pulsePos = 1'b0;
                    nxt_st.pulseNeg = 1'b0;
                    nxt_st.anaA = sym[SYM_POS];
                    nxt_st.anaB = sym[SYM_NEG];
                end
                default: begin
                    nxt_st.pulsePos = 1'b0;
                    nxt_st.pulseNeg = 1'b0;
                    nxt_st.anaA = 1'b0;
                    nxt_st.anaB = 1'b0;
                end
            endcase
        end else if (xclkFall && (st_ff.phase != PH_IDLE)) begin
            // falling edge: second half of the bit
            nxt_st.phase = PH_SECOND;
            // half-bauded rails return to idle, full-bauded ones hold
            if ((mode == MODE_DUAL) && !st_ff.baud_width_select) begin
                nxt_st.pulsePos = 1'b0;
                nxt_st.pulseNeg = 1'b0;
            end
            // cmi zero goes high mid-bit, giving its half duty symbol
            if ((mode == MODE_OPTICAL) && st_ff.cmiZero) begin
                nxt_st.pulsePos = 1'b1;
            end
            // analog pulses are half-bauded
            nxt_st.anaA = 1'b0;
            nxt_st.anaB = 1'b0;
        end

        // polarity: rails active low unless inverted, optical data active high
        case (mode)
            MODE_DUAL: begin
                nxt_st.pinPos = nxt_st.pulsePos ^ ~st_ff.output_polarity_select;
                nxt_st.pinNeg = nxt_st.pulseNeg ^ ~st_ff.output_polarity_select;
            end
            MODE_OPTICAL: begin
                nxt_st.pinPos = nxt_st.pulsePos ^ st_ff.output_polarity_select;
                nxt_st.pinNeg = nxt_st.pulseNeg;
            end
            default: begin
                nxt_st.pinPos = 1'b0;
                nxt_st.pinNeg = 1'b0;
            end
        endcase
        nxt_st.pinA = nxt_st.anaA;
        nxt_st.pinB = nxt_st.anaB;

        // output enables; the tristate bit set at reset keeps all pins off
        nxt_st.digOe = st_ff.line_side_select & ~st_ff.transmit_tristate_ctl;
        nxt_st.anaOe = ~st_ff.line_side_select & st_ff.transmit_coding_select
            & ~st_ff.transmit_tristate_ctl;
    end

    // state register; control takes the reset value, all else clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
            st_ff.line_side_select <= CTRL_RESET[CTRL_LINE_SIDE];
            st_ff.transmit_coding_select <= CTRL_RESET[CTRL_CODING];
            st_ff.transmit_tristate_ctl <= CTRL_RESET[CTRL_TRISTATE];
            st_ff.baud_width_select <= CTRL_RESET[CTRL_BAUD];
            st_ff.output_polarity_select <= CTRL_RESET[CTRL_POLARITY];
            st_ff.cmiSelect <= CTRL_RESET[CTRL_CMI];
            st_ff.frameCount <= FRAME_CNT_RESET;
            st_ff.phase <= PH_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pin drivers; marker is valid only in optical mode
    assign tx_rail_positive = st_ff.pinPos;
    assign tx_rail_positive_oe = st_ff.digOe;
    assign tx_rail_negative = st_ff.pinNeg;
    assign tx_rail_negative_oe = st_ff.digOe;
    assign tx_analog_line_a = st_ff.pinA;
    assign tx_analog_line_a_oe = st_ff.anaOe;
    assign tx_analog_line_b = st_ff.pinB;
    assign tx_analog_line_b_oe = st_ff.anaOe;

endmodule // transmit_line_output_port

// ===== hdl/tx_line_buffer.sv
// module: two-entry symbol buffer between framer core and line output stage
`timescale 1ns/1ps
module tx_line_buffer
    import tx_line_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [SYM_W-1:0] inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output logic [SYM_W-1:0] outData
);

    typedef struct packed {
        logic [BUF_DEPTH-1:0][SYM_W-1:0] mem;
        logic wrPtr;
        logic rdPtr;
        logic [1:0] count;
    } buf_t;

    buf_t buf_ff;
    buf_t nxt_buf;
    logic push;
    logic pop;

    // honest full and empty flags from the fill count
    assign inReady = (buf_ff.count != 2'(BUF_DEPTH));
    assign outValid = (buf_ff.count != 2'h0);
    assign outData = buf_ff.mem[buf_ff.rdPtr];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // next state: write entry, advance pointers, track count
    always_comb begin
        nxt_buf = buf_ff;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (push && (buf_ff.wrPtr == 1'(i))) begin
                nxt_buf.mem[i] = inData;
            end
        end
        if (push) begin
            nxt_buf.wrPtr = ~buf_ff.wrPtr;
        end
        if (pop) begin
            nxt_buf.rdPtr = ~buf_ff.rdPtr;
        end
        case ({push, pop})
            2'b10: nxt_buf.count = buf_ff.count + 2'h1;
            2'b01: nxt_buf.count = buf_ff.count - 2'h1;
            default: nxt_buf.count = buf_ff.count;
        endcase
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            buf_ff <= '0;
        end else begin
            buf_ff <= nxt_buf;
        end
    end

endmodule // tx_line_buffer

// ===== hdl/tx_line_pkg.sv
// package: register map, field positions, symbol layout and states of the transmit line port
package tx_line_pkg;

    // apb register map (byte addresses, one aligned word each)
    localparam int APB_AW = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;

    // control register field positions
    localparam int CTRL_LINE_SIDE = 0;
    localparam int CTRL_CODING = 1;
    localparam int CTRL_TRISTATE = 2;
    localparam int CTRL_BAUD = 3;
    localparam int CTRL_POLARITY = 4;
    localparam int CTRL_CMI = 5;
    localparam int CTRL_W = 6;

    // control value after reset: analog side, tristate requested
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h04;

    // status register field positions
    localparam int ST_UNDERRUN = 0;
    localparam int ST_DIG_OE = 1;
    localparam int ST_ANA_OE = 2;
    localparam int ST_MODE_LO = 3;
    localparam int ST_MODE_HI = 4;
    localparam int ST_BUF_VALID = 5;
    localparam int ST_FRAME_LO = 16;
    localparam int ST_FRAME_HI = 31;

    // frame counter width and reset value
    localparam int FRAME_CNT_W = 16;
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RESET = 16'h0000;

    // symbol from the framer core: frame start, positive rail / data, negative rail
    localparam int SYM_W = 3;
    localparam int SYM_FRAME = 2;
    localparam int SYM_POS = 1;
    localparam int SYM_NEG = 0;

    // buffer depth in symbols
    localparam int BUF_DEPTH = 2;

    // bit phase within one transmit clock period
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FIRST = 2'b01,
        PH_SECOND = 2'b11
    } phase_t;

    // active line mode
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'b00,
        MODE_OPTICAL = 2'b01,
        MODE_DUAL = 2'b11
    } line_mode_t;

endpackage

// ===== verification/line_far_end.sv
// model: far-side receiver clocking the port
`timescale 1ns/1ps
module line_far_end
(
    // bench request
    input wire logic [15:0] bitsWanted,
    // clock towards the port
    output logic transmit_clock,
    // pins from the port
    input wire logic tx_analog_line_a,
    input wire logic tx_analog_line_b,
    input wire logic tx_rail_positive,
    input wire logic tx_rail_negative
);
    logic [7:0] cap [64];
    logic [3:0] first;
    logic [15:0] bitsDone = 16'h0000;
    initial transmit_clock = 1'b0;
    // 80 ns bits off the mclk edges; idle low between bursts
    // no loopback here, so every marker is valid
    always begin
        wait (bitsDone < bitsWanted);
        #3;
        transmit_clock = 1'b1;
        #36;
        first = {tx_rail_positive, tx_rail_negative, tx_analog_line_a, tx_analog_line_b};
        #4;
        transmit_clock = 1'b0;
        #36;
        cap[bitsDone[5:0]] = {first[3:2], tx_rail_positive, tx_rail_negative,
                              first[1:0], tx_analog_line_a, tx_analog_line_b};
        bitsDone = bitsDone + 16'h0001;
        #1;
    end
endmodule // line_far_end

// ===== verification/transmit_line_output_port_test.sv
// testbench: directed scenarios for the line port
`timescale 1ns/1ps
module transmit_line_output_port_test;
    import tx_line_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic symValid = 1'b0;
    logic symFrameStart = 1'b0;
    logic symPos = 1'b0;
    logic symNeg = 1'b0;
    logic [15:0] bitsWanted = 16'h0000;
    logic [31:0] prdata;
    logic pready, pslverr, symReady, transmit_clock, readyPre, cmiLvl;
    logic tx_analog_line_a, tx_analog_line_a_oe, tx_analog_line_b, tx_analog_line_b_oe;
    logic tx_rail_positive, tx_rail_positive_oe, tx_rail_negative, tx_rail_negative_oe;
    // symbols {frame, pos, neg}; idle tail
    logic [2:0] pat [8] = '{3'b110, 3'b001, 3'b011, 3'b000, 3'b100, 3'b010, 3'b000, 3'b000};
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int feedIdx = 0;
    int feedLen = 0;

    transmit_line_output_port transmit_line_output_port_i (
        .mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .symValid, .symReady, .symFrameStart, .symPos, .symNeg, .transmit_clock,
        .tx_analog_line_a, .tx_analog_line_a_oe, .tx_analog_line_b, .tx_analog_line_b_oe,
        .tx_rail_positive, .tx_rail_positive_oe, .tx_rail_negative, .tx_rail_negative_oe
    );
    line_far_end line_far_end_i (
        .bitsWanted, .transmit_clock, .tx_analog_line_a, .tx_analog_line_b,
        .tx_rail_positive, .tx_rail_negative
    );

    // system clock
    always #4 mclk = ~mclk;
    // core side: ready sampled mid-cycle to avoid edge races
    always @(negedge mclk) readyPre = symReady;
    always @(posedge mclk) begin
        if (symValid && readyPre) feedIdx = feedIdx + 1;
        symValid <= (feedIdx < feedLen);
        {symFrameStart, symPos, symNeg} <= pat[feedIdx[2:0]];
    end
    // hang guard
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pins(input int k, input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: bit %0d got %b exp %b", $time, k, got, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 100) begin
            n = n + 1;
            @(posedge mclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                          input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk_word(q & m, x, "read data");
        chk_word({31'h0, e}, {31'h0, xe}, "slave error");
    endtask

    // expected {first half, second half} pins per symbol
    function automatic logic [3:0] expect_bit(input logic [5:0] c, input logic [2:0] s);
        logic pol;
        pol = c[CTRL_POLARITY];
        if (!c[CTRL_LINE_SIDE]) return {s[1:0], 2'b00};
        if (c[CTRL_CODING]) return {s[1:0], c[CTRL_BAUD] ? s[1:0] : 2'b00} ^ {4{~pol}};
        if (!c[CTRL_CMI]) return {s[1] ^ pol, s[2], s[1] ^ pol, s[2]};
        if (!s[1]) return {1'b0, s[2], 1'b1, s[2]};
        cmiLvl = ~cmiLvl;
        return {cmiLvl, s[2], cmiLvl, s[2]};
    endfunction

    // fill the buffer, send n bits, judge each
    task automatic run_bits(input logic [5:0] c, input int n);
        logic [15:0] base;
        logic [7:0] g;
        int k;
        base = line_far_end_i.bitsDone;
        @(negedge mclk);
        feedIdx = 0;
        feedLen = 6;
        repeat (8) @(negedge mclk);
        chk_word({31'h0, symReady}, 32'h0, "ready while full");
        @(posedge mclk);
        bitsWanted <= base + n[15:0];
        k = 0;
        while (line_far_end_i.bitsDone != base + n[15:0] && k < 20 * n) begin
            k = k + 1;
            @(posedge mclk);
        end
        for (k = 0; k < n; k++) begin
            g = line_far_end_i.cap[base[5:0] + k[5:0]];
            chk_pins(k, c[0] ? g[7:4] : g[3:0], expect_bit(c, pat[k[2:0]]));
        end
    endtask

    // reset state and an unmapped address
    task automatic t_reset_state();
        chk_word({28'h0, tx_analog_line_a_oe, tx_analog_line_b_oe, tx_rail_positive_oe,
                  tx_rail_negative_oe}, 32'h0, "enables");
        reg_rd(ADDR_CTRL, 32'h000000ff, 32'h00000004, 1'b0);
        reg_rd(ADDR_STATUS, 32'hffffffff, 32'h0, 1'b0);
        reg_rd(12'h008, 32'hffffffff, 32'h0, 1'b1);
    endtask

    // write control, then judge all four enables as {a, b, pos, neg}
    task automatic oe_step(input logic [31:0] d, input logic [3:0] x);
        reg_wr(ADDR_CTRL, d);
        repeat (2) @(negedge mclk);
        chk_word({28'h0, tx_analog_line_a_oe, tx_analog_line_b_oe, tx_rail_positive_oe,
                  tx_rail_negative_oe}, {28'h0, x}, "enables");
    endtask

    // enables follow line side, coding and tristate
    task automatic t_tristate();
        oe_step(32'h00000007, 4'h0);
        oe_step(32'h00000001, 4'h3);
        oe_step(32'h00000000, 4'h0);
        oe_step(32'h00000002, 4'hc);
        run_bits(6'h02, 6);
    endtask

    // dual rail half bauded, then underrun flag; two frames per run so far
    task automatic t_dual_half();
        reg_wr(ADDR_CTRL, 32'h00000003);
        run_bits(6'h03, 7);
        reg_rd(ADDR_STATUS, 32'hffff003f, 32'h0004001b, 1'b0);
        reg_wr(ADDR_STATUS, 32'h00000001);
        reg_rd(ADDR_STATUS, 32'hffff003f, 32'h0004001a, 1'b0);
    endtask

    // dual rail full bauded, inverted
    task automatic t_dual_full();
        reg_wr(ADDR_CTRL, 32'h0000001b);
        run_bits(6'h1b, 6);
    endtask

    // optical nrz with marker, both polarities
    task automatic t_optical();
        reg_wr(ADDR_CTRL, 32'h00000001);
        run_bits(6'h01, 6);
        reg_wr(ADDR_CTRL, 32'h00000011);
        run_bits(6'h11, 6);
    endtask

    // optical cmi after a mid-run reset
    task automatic t_cmi();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        cmiLvl = 1'b0;
        reg_wr(ADDR_CTRL, 32'h00000021);
        run_bits(6'h21, 6);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        t_reset_state();
        t_tristate();
        t_dual_half();
        t_dual_full();
        t_optical();
        t_cmi();
        report_and_stop();
    end
endmodule // transmit_line_output_port_test

// ===== verification/tx_line_port_chk.sv
// checker: enable and launch-edge properties of the port
`timescale 1ns/1ps
module tx_line_port_chk
    import tx_line_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // line
    input wire logic transmit_clock,
    input wire logic tx_analog_line_a_oe,
    input wire logic tx_rail_positive,
    input wire logic tx_rail_positive_oe,
    input wire logic tx_rail_negative,
    input wire logic tx_rail_negative_oe
);
    logic [CTRL_W-1:0] ctrl_ff;
    logic [3:0] sync_ff;
    logic side, digEn, anaEn, optMode, optNrz, dualFull, riseNear;
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // control shadow and a pin history marking recent rises
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RESET;
            sync_ff <= 4'h0;
        end else begin
            sync_ff <= {sync_ff[2:0], transmit_clock};
            if (psel && penable && pwrite && pstrb[0] && paddr == ADDR_CTRL) begin
                ctrl_ff <= pwdata[CTRL_W-1:0];
            end
        end
    end
    // decoded modes
    assign side = ctrl_ff[CTRL_LINE_SIDE];
    assign digEn = side && !ctrl_ff[CTRL_TRISTATE];
    assign anaEn = !side && ctrl_ff[CTRL_CODING] && !ctrl_ff[CTRL_TRISTATE];
    assign optMode = side && !ctrl_ff[CTRL_CODING];
    assign optNrz = optMode && !ctrl_ff[CTRL_CMI];
    assign dualFull = side && ctrl_ff[CTRL_CODING] && ctrl_ff[CTRL_BAUD];
    assign riseNear = sync_ff[0] && !sync_ff[3];
    // pin change with control steady for three cycles
    sequence s_quiet_change(sig, mode);
        mode && $changed(sig) && ctrl_ff == $past(ctrl_ff, 3);
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_dig_oe;
        tx_rail_positive_oe == $past(digEn);
    endproperty
    a_dig_oe: assert property (p_dig_oe) else $error("digital enable wrong");
    property p_oe_pair;
        tx_rail_negative_oe == tx_rail_positive_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("digital enables differ");
    property p_ana_oe;
        tx_analog_line_a_oe == $past(anaEn);
    endproperty
    a_ana_oe: assert property (p_ana_oe) else $error("analog enable wrong");
    property p_one_side;
        !(tx_analog_line_a_oe && tx_rail_positive_oe);
    endproperty
    a_one_side: assert property (p_one_side) else $error("both sides driven");
    property p_marker_rise;
        s_quiet_change(tx_rail_negative, optMode) |-> $past(riseNear);
    endproperty
    a_marker_rise: assert property (p_marker_rise) else $error("marker off rise");
    property p_nrz_rise;
        s_quiet_change(tx_rail_positive, optNrz) |-> $past(riseNear);
    endproperty
    a_nrz_rise: assert property (p_nrz_rise) else $error("nrz data off rise");
    property p_full_rise;
        s_quiet_change(tx_rail_positive, dualFull) |-> $past(riseNear);
    endproperty
    a_full_rise: assert property (p_full_rise) else $error("full rail off rise");
    property p_bad_addr;
        s_access ##0 (paddr != ADDR_CTRL && paddr != ADDR_STATUS) |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped not refused");
    property p_zero_wait;
        s_access |-> pready;
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("access phase stalled");
endmodule // tx_line_port_chk

bind transmit_line_output_port tx_line_port_chk tx_line_port_chk_i (
    .mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
    .transmit_clock, .tx_analog_line_a_oe, .tx_rail_positive, .tx_rail_positive_oe,
    .tx_rail_negative, .tx_rail_negative_oe
);
